// file: hw/pdw_pkg.sv
package pdw_pkg;
    // modbus register numbers, word addressed
    localparam logic [15:0] REG_TIMEOUT = 16'h07d0;
    localparam logic [15:0] REG_FAULT_MODE = 16'h07d2;
    localparam logic [15:0] REG_CAUSE = 16'h07d4;
    localparam logic [15:0] REG_COMMAND = 16'h07d6;
    localparam logic [15:0] REG_STATUS = 16'h1f3c;
    localparam logic [15:0] TIMEOUT_RST = 16'h01f4;
    localparam logic [15:0] TIMEOUT_MIN = 16'h00c8;
    localparam logic [15:0] TIMEOUT_MAX = 16'hfde8;
    localparam logic [15:0] MODE_RST = 16'h0001;
    localparam logic [15:0] MODE_ZERO = 16'h0000;
    localparam logic [15:0] MODE_RESET = 16'h0001;
    localparam logic [15:0] MODE_HOLD = 16'h0002;
    localparam logic [15:0] CMD_ACK = 16'h0002;
    localparam logic [15:0] CAUSE_NONE = 16'h0000;
    localparam logic [15:0] CAUSE_WDOG = 16'h0001;
    localparam logic [15:0] CAUSE_MAX = 16'h000d;
    localparam logic [15:0] ERR_OK = 16'h0000;
    localparam logic [15:0] ERR_AUTOCFG = 16'h00a9;
    localparam logic [15:0] ERR_ADDR = 16'h0002;
    localparam int STAT_OK_BIT = 0;
    localparam int STAT_FAIL_BIT = 1;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        proc_data;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pdw_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
        logic [15:0] err;
    } pdw_rsp_t;
endpackage

// file: hw/pdw_watchdog.sv
`timescale 1ns/1ps
// Contract
// - mode 0 fault drives all digital and analog outputs to zero.
// - mode 1 fault clears digital outputs, analog outputs take defaults.
// - mode 2 fault holds every output at its pre-fault value.
// - fault mode is a 16-bit register at 2002, written by client.
// - after reset watchdog is enabled with 500 ms timeout.
// - watchdog unarmed until first process-data write, which arms it.
// - each process-data write before expiry restarts the interval.
// - process-data reads never touch the watchdog counter.
// - armed expiry applies fault mode and sets network-failure flag.
// - failure records cause 0001..000D, readable at register 2004.
// - once armed, client cannot stop watchdog; silence still expires it.
// - outputs stay disabled after fault until failure is acknowledged.
// - writing 0002 to command register 2006 acknowledges the failure.
// - acknowledgement restarts the watchdog; silence faults again.
// - timeout changes only accepted in init state; the code also accepts them in fault state.
// - timeout register at 2000, 16 bits, accepts 200..65000 ms.
// - zero timeout in init state disables watchdog; otherwise ignored. The code also accepts it in fault state.
// - auto-configuration rejects process-data access with error 00A9.
// - auto-configuration holds all station outputs in reset state.
// - local bus starts after auto-config only if configurations match.
// - status bit 1 reads one while network failure pending.
module pdw_watchdog
    import pdw_pkg::*;
#(
    parameter int DOUT_W = 16,
    parameter int AOUT_N = 2,
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic sys_clk, // 20 MHz
    input wire logic rst_n, // async, active low
    input wire pdw_req_t req, // register / process-data request
    output pdw_rsp_t rsp, // one-cycle answer
    input wire logic [DOUT_W-1:0] dout_cmd, // client digital image
    input wire logic [AOUT_N*16-1:0] aout_cmd, // client analog image
    input wire logic [AOUT_N*16-1:0] aout_dflt, // terminal defaults
    input wire logic autocfg_on, // auto-configuration mode
    input wire logic cfg_match, // detected equals reference config
    input wire logic bus_ok, // local bus error-free
    output logic [DOUT_W-1:0] dout, // station digital outputs
    output logic [AOUT_N*16-1:0] aout, // station analog outputs
    output logic net_fail, // network failure pending
    output logic outputs_en, // outputs enabled
    output logic bus_start // local bus run request
);
    initial begin
        if (DOUT_W < 1 || DOUT_W > 16)
            $error("pdw_watchdog: DOUT_W must be 1 to 16");
        if (AOUT_N < 1)
            $error("pdw_watchdog: AOUT_N must be at least 1");
        if (TICK_CYC < 1)
            $error("pdw_watchdog: TICK_CYC must be at least 1");
    end

    typedef enum logic [1:0] {ST_INIT, ST_ARMED, ST_FAULT} pdw_state_t;

    // two-flop release keeps reset recovery off the async edge
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_ok = rst_s2_q;

    pdw_state_t state_q;
    pdw_state_t state_d;
    logic [15:0] tmo_q;
    logic [15:0] mode_q;
    logic [15:0] cause_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic autocfg_q;
    logic [DOUT_W-1:0] dout_q;
    logic [DOUT_W-1:0] dout_d;
    logic [AOUT_N*16-1:0] aout_q;
    logic [AOUT_N*16-1:0] aout_d;
    pdw_rsp_t rsp_q;
    pdw_rsp_t rsp_d;
    logic bus_start_q;
    logic net_fail_q;
    logic outputs_en_q;

    wire logic acc = req.valid;
    wire logic wr = acc && req.write;
    wire logic pd_acc = acc && req.proc_data;
    // reject process data while auto-configuring
    // autocfg rejection
    wire logic pd_rej = pd_acc && autocfg_on;
    // reads and refused writes leave the counter alone
    // only writes trigger
    wire logic pd_wr = pd_acc && req.write && !autocfg_on;
    wire logic reg_wr = wr && !req.proc_data;
    wire logic wr_tmo = reg_wr && req.addr == REG_TIMEOUT;
    wire logic wr_mode = reg_wr && req.addr == REG_FAULT_MODE;
    wire logic ack = reg_wr && req.addr == REG_COMMAND && req.wdata == CMD_ACK;
    // fault state doubles as the init state for config writes
    wire logic in_init = state_q == ST_INIT || state_q == ST_FAULT;
    wire logic tmo_ok = req.wdata == 16'h0000
        || (req.wdata >= TIMEOUT_MIN && req.wdata <= TIMEOUT_MAX);
    wire logic tmo_take = wr_tmo && in_init && tmo_ok;
    wire logic enabled = tmo_q != 16'h0000;
    // count+1 so expiry lands on the tick that completes tmo ms
    // timeout on reach
    wire logic expire = state_q == ST_ARMED && tick_q && (cnt_q + 16'h0001) >= tmo_q;
    // out-of-range modes are dropped, the old mode stays
    wire logic mode_ok = req.wdata <= MODE_HOLD;

    always_ff @(posedge sys_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_INIT: begin
                if (pd_wr && enabled) begin
                    state_d = ST_ARMED;
                    cnt_d = 16'h0000;
                end
            end
            ST_ARMED: begin
                if (expire) begin
                    state_d = ST_FAULT;
                end else if (pd_wr) begin
                    cnt_d = 16'h0000;
                end else if (tick_q) begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            ST_FAULT: begin
                if (ack) begin
                    state_d = enabled ? ST_ARMED : ST_INIT;
                    cnt_d = 16'h0000;
                end
            end
            default: state_d = ST_INIT;
        endcase
    end

    // fault output images per mode; hold keeps current registers
    logic [DOUT_W-1:0] dout_fault;
    wire logic [AOUT_N*16-1:0] aout_fault;
    always_comb begin
        case (mode_q)
            MODE_ZERO: dout_fault = '0;
            MODE_RESET: dout_fault = '0;
            default: dout_fault = dout_q;
        endcase
    end

    // analog fault value per channel; each terminal brings its own default
    for (genvar ch = 0; ch < AOUT_N; ch++) begin : g_aout
        wire logic [15:0] held_w = aout_q[ch*16 +: 16];
        wire logic [15:0] dflt_w = aout_dflt[ch*16 +: 16];
        assign aout_fault[ch*16 +: 16] = (mode_q == MODE_ZERO) ? 16'h0000
            : (mode_q == MODE_RESET) ? dflt_w
            : held_w;
    end

    always_comb begin
        dout_d = dout_cmd;
        aout_d = aout_cmd;
        if (autocfg_on) begin
            dout_d = '0;
            aout_d = aout_dflt;
        end else if (expire || (state_q == ST_FAULT && !ack)) begin
            dout_d = dout_fault;
            aout_d = aout_fault;
        end
    end

    // every request is answered one cycle later
    always_comb begin
        rsp_d = '0;
        rsp_d.valid = acc;
        if (pd_rej) begin
            rsp_d.err = ERR_AUTOCFG;
        end else if (acc && !req.proc_data && !req.write) begin
            case (req.addr)
                REG_TIMEOUT: rsp_d.rdata = tmo_q;
                REG_FAULT_MODE: rsp_d.rdata = mode_q;
                REG_CAUSE: rsp_d.rdata = cause_q;
                REG_COMMAND: rsp_d.rdata = 16'h0000;
                REG_STATUS: begin
                    rsp_d.rdata[STAT_OK_BIT] = bus_ok && state_q != ST_FAULT;
                    rsp_d.rdata[STAT_FAIL_BIT] = state_q == ST_FAULT;
                end
                default: rsp_d.err = ERR_ADDR;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            state_q <= ST_INIT;
            cnt_q <= 16'h0000;
            dout_q <= '0;
            aout_q <= '0;
            rsp_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            dout_q <= dout_d;
            aout_q <= aout_d;
            rsp_q <= rsp_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            tmo_q <= TIMEOUT_RST;
            mode_q <= MODE_RST;
            cause_q <= CAUSE_NONE;
        end else begin
            if (tmo_take)
                tmo_q <= req.wdata;
            if (wr_mode && mode_ok)
                mode_q <= req.wdata;
            if (expire)
                cause_q <= CAUSE_WDOG;
            else if (ack && state_q == ST_FAULT)
                cause_q <= CAUSE_NONE;
        end
    end

    // start only on matching config
    // no memory of earlier runs: the configuration may change meanwhile
    always_ff @(posedge sys_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            autocfg_q <= 1'b0;
            bus_start_q <= 1'b0;
        end else begin
            autocfg_q <= autocfg_on;
            bus_start_q <= !autocfg_on && cfg_match;
        end
    end

    // flags registered so the pins come straight from flops
    always_ff @(posedge sys_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            net_fail_q <= 1'b0;
            outputs_en_q <= 1'b1;
        end else begin
            net_fail_q <= state_d == ST_FAULT;
            outputs_en_q <= state_d != ST_FAULT && !autocfg_on;
        end
    end

    assign dout = dout_q;
    assign aout = aout_q;
    assign rsp = rsp_q;
    assign bus_start = bus_start_q;
    assign net_fail = net_fail_q;
    assign outputs_en = outputs_en_q;
endmodule

// file: sim/pdw_client.sv
`timescale 1ns/1ps
module pdw_client
    import pdw_pkg::*;
(
    input wire logic sys_clk, // bench clock
    output pdw_req_t req, // request to the device
    input wire pdw_rsp_t rsp // device answer
);
    int miss = 0;
    initial req = '0;
    task automatic xfer(input logic w, pd, input logic [15:0] a, d);
        int n;
        @(negedge sys_clk);
        req = '{1'b1, w, pd, a, d};
        @(negedge sys_clk);
        // released fields flip so a stale value never looks valid
        req = '{1'b0, ~w, ~pd, ~a, ~d};
        for (n = 0; n < 8 && rsp.valid !== 1'b1; n++) @(negedge sys_clk);
        if (n == 8) miss++;
    endtask
endmodule

// file: sim/pdw_watchdog_monitor.sv
`timescale 1ns/1ps
module pdw_watchdog_monitor
    import pdw_pkg::*;
#(
    parameter int DOUT_W = 16
) (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire pdw_req_t req, // request
    input wire pdw_rsp_t rsp, // answer
    input wire logic autocfg_on, // autoconfig
    input wire logic cfg_match, // config equal
    input wire logic [DOUT_W-1:0] dout, // digital out
    input wire logic net_fail, // failure flag
    input wire logic outputs_en, // enable
    input wire logic bus_start // bus run
);
    logic [1:0] up_q;
    // internal reset copy lags rst_n by three edges
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    wire rd = req.valid && !req.write;
    wire ack = req.valid && req.write && !req.proc_data && req.addr == REG_COMMAND
        && req.wdata == CMD_ACK;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || up_q != 2'h3);
    autocfg_err_a: assert property (
        req.valid && req.proc_data && autocfg_on |=> rsp.valid && rsp.err == ERR_AUTOCFG)
        else $error("autocfg access not refused");
    cfg_out_a: assert property (autocfg_on [*3] |-> dout == '0)
        else $error("outputs live in autocfg");
    bus_go_a: assert property (1'b1 |=> bus_start == $past(!autocfg_on && cfg_match))
        else $error("bus start wrong");
    cause_rng_a: assert property (
        rd && req.addr == REG_CAUSE && net_fail |=> rsp.rdata inside {[CAUSE_WDOG:CAUSE_MAX]})
        else $error("cause out of range");
    stat_bit_a: assert property (
        rd && req.addr == REG_STATUS |=> rsp.rdata[STAT_FAIL_BIT] == $past(net_fail))
        else $error("status fail bit wrong");
    ack_clr_a: assert property (ack && net_fail && !autocfg_on |=> !net_fail && outputs_en)
        else $error("ack did not clear");
    fail_dis_a: assert property (net_fail |-> !outputs_en)
        else $error("outputs on in fault");
    fail_hold_a: assert property (net_fail && !ack |=> net_fail)
        else $error("fault left without ack");
    tmo_rng_a: assert property (rd && req.addr == REG_TIMEOUT |=>
        rsp.rdata == 16'h0000 || rsp.rdata inside {[TIMEOUT_MIN:TIMEOUT_MAX]})
        else $error("timeout out of range");
    mode_rng_a: assert property (rd && req.addr == REG_FAULT_MODE |=> rsp.rdata <= MODE_HOLD)
        else $error("mode out of range");
    cover property ($rose(net_fail));
    cover property (ack && net_fail);
    cover property (req.valid && req.proc_data && autocfg_on);
endmodule
bind pdw_watchdog pdw_watchdog_monitor #(.DOUT_W(DOUT_W)) pdw_watchdog_monitor_inst (
    .sys_clk, .rst_n, .req, .rsp, .autocfg_on, .cfg_match, .dout, .net_fail,
    .outputs_en, .bus_start
);

// file: sim/process_data_watchdog_fault_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; \
    if ((e) !== (s)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module process_data_watchdog_fault_tb_top;
    import pdw_pkg::*;
    logic sys_clk = 0, rst_n = 0, autocfg_on = 0, cfg_match = 1, bus_ok = 1;
    logic net_fail, outputs_en, bus_start;
    logic [15:0] dout_cmd = '0, dout;
    logic [31:0] aout_cmd = '0, aout, aout_dflt = 32'h0fa0_07d0;
    pdw_req_t req;
    pdw_rsp_t rsp;
    int err_count = 0, n_tests = 0;
    logic [32:0] expq[$];
    logic [32:0] e;
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    pdw_watchdog #(.TICK_CYC(10)) pdw_watchdog_inst (.sys_clk, .rst_n, .req, .rsp,
        .dout_cmd, .aout_cmd, .aout_dflt, .autocfg_on, .cfg_match, .bus_ok, .dout,
        .aout, .net_fail, .outputs_en, .bus_start);
    pdw_client pdw_client_inst (.sys_clk, .req, .rsp);
    // sample off the launching edge so the answer is settled
    always @(negedge sys_clk) begin
        if (rsp.valid === 1'b1) begin
            e = expq.pop_front();
            `CHK("err", e[15:0], rsp.err)
            if (e[32]) `CHK("rdata", e[31:16], rsp.rdata)
        end
    end
    task test_done;
        `CHK("lost rsp", 0, pdw_client_inst.miss)
        `CHK("queue", 0, expq.size())
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task rq(input logic w, pd, input logic [15:0] a, d, input logic c, input logic [15:0] x, er);
        expq.push_back({c, x, er});
        pdw_client_inst.xfer(w, pd, a, d);
    endtask
    task rd(input logic [15:0] a, x); rq(0, 0, a, 0, 1, x, ERR_OK); endtask
    task wr(input logic [15:0] a, d); rq(1, 0, a, d, 0, 0, ERR_OK); endtask
    task pw(input logic [15:0] d, er); rq(1, 1, 16'h0180, d, 0, 0, er); endtask
    task cyc(input int n); repeat (n) @(negedge sys_clk); endtask
    task wait_fail(input int n);
        int k;
        for (k = 0; k < n && net_fail !== 1'b1; k++) cyc(1);
        if (k == n) begin
            err_count++;
            test_done();
        end
    endtask
    initial begin
        logic [15:0] v;
        logic [31:0] av;
        int i;
        v = $urandom(10);
        cyc(12);
        rst_n = 1;
        cyc(4);
        rd(REG_TIMEOUT, TIMEOUT_RST);
        rd(REG_FAULT_MODE, MODE_RST);
        rq(0, 0, 16'h0005, 0, 0, 0, ERR_ADDR);
        rd(REG_STATUS, 16'h0001);
        wr(REG_TIMEOUT, 16'h0064);
        rd(REG_TIMEOUT, TIMEOUT_RST);
        wr(REG_TIMEOUT, TIMEOUT_MIN);
        rd(REG_TIMEOUT, TIMEOUT_MIN);
        for (i = 0; i < 3; i++) begin
            v = $urandom;
            av = $urandom;
            dout_cmd = v;
            aout_cmd = av;
            wr(REG_FAULT_MODE, 16'(i));
            pw(v, ERR_OK);
            repeat (3) begin cyc(1400); pw(v, ERR_OK); end
            `CHK("live d", v, dout)
            `CHK("live a", av, aout)
            wr(REG_TIMEOUT, 16'h0000);
            rd(REG_TIMEOUT, TIMEOUT_MIN);
            repeat (19) begin rd(REG_TIMEOUT, TIMEOUT_MIN); cyc(97); end
            `CHK("quiet", 1'b0, net_fail)
            wait_fail(300);
            `CHK("en", 1'b0, outputs_en)
            dout_cmd = ~v;
            aout_cmd = ~av;
            cyc(2);
            `CHK("dout", (i == 2) ? v : 16'h0000, dout)
            `CHK("aout", (i == 2) ? av : (i == 1) ? aout_dflt : 32'h0, aout)
            rd(REG_CAUSE, CAUSE_WDOG);
            rd(REG_STATUS, 16'h0002);
            wr(REG_COMMAND, 16'h0001);
            `CHK("held", 1'b1, net_fail)
            wr(REG_COMMAND, CMD_ACK);
            `CHK("ack", 1'b0, net_fail)
            rd(REG_CAUSE, CAUSE_NONE);
        end
        wait_fail(2100);
        wr(REG_TIMEOUT, 16'h0000);
        wr(REG_COMMAND, CMD_ACK);
        pw(v, ERR_OK);
        cyc(2500);
        `CHK("off", 1'b0, net_fail)
        autocfg_on = 1;
        cyc(3);
        pw(v, ERR_AUTOCFG);
        `CHK("cfg dout", 16'h0000, dout)
        `CHK("cfg bus", 1'b0, bus_start)
        cfg_match = 0;
        autocfg_on = 0;
        cyc(3);
        `CHK("mismatch", 1'b0, bus_start)
        cfg_match = 1;
        cyc(3);
        `CHK("match", 1'b1, bus_start)
        cyc(3);
        test_done();
    end
endmodule
